/* File: rtl/_unused.sv */
`default_nettype none
`default_nettype wire

/* File: rtl/flr_formatter.sv */
// Purpose: Peak tracking, event capture and record read-out of the fault log.
// Assumes: Measurement samples arrive on clk, one step per valid cycle.
// Notes: Captured log is locked until reset; host link runs on link_clk.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - Track maxima of both output voltages, currents and input voltage.
// R2 - Peak output voltages of channels 0 and 1 at bytes 11 and 13.
// R3 - Peak output currents of channels 0 and 1 at bytes 15 and 17.
// R4 - Peak input voltage at bytes 19 and 20.
// R5 - External temperatures of last event at bytes 21 and 23.
// R6 - Die temperature of last event at bytes 25 and 26.
// R7 - Newest page from byte 27: voltages, then currents from byte 31.
// R8 - Newest page holds exactly one full multiplexer pass around the fault.
// R9 - After a fault, keep converting until the pass's last step completes.
// R10 - After that pass, write header and all six pages to storage.
// R11 - Every word is sent high byte first.
// R12 - Block read gives 147 bytes with a log, length zero without.
// R13 - Store command triggers the same transfer as a fault.
// R14 - After a peak clear, each peak restarts from its next measurement.
module flr_formatter
    import flr_pkg::*;
#(
    parameter int MUX_LAST_STEP = LAST_STEP
) (
    input wire logic clk,
    input wire logic rst,
    input wire flr_meas_s meas,
    input wire logic peak_clear_command,
    input wire logic fault,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire flr_cmd_s link_cmd,
    input wire logic link_byte_req,
    output flr_byte_s link_byte,
    output logic log_present,
    output logic store_busy
);

    // ==========================================================
    // State
    typedef struct packed {
        // Capture sequencer state
        flr_st_e st;
        // Page being copied to storage
        logic [2:0] pg;
        // Running maxima, one word per quantity
        logic [NUM_PEAKS-1:0][15:0] pk;
        // Peak holds a sample taken since the last clear
        logic [NUM_PEAKS-1:0] fresh;
        // Page words of the pass in progress
        logic [PAGE_WORDS-1:0][15:0] work;
        // Latest temperature readings
        logic [NUM_TEMPS-1:0][15:0] tmp;
        // Cyclic buffer of completed passes
        logic [NUM_PAGES-1:0][PAGE_WORDS-1:0][15:0] ring;
        // Next slot of the cyclic buffer
        logic [2:0] wptr;
        // Stored copy of the pages
        logic [NUM_PAGES-1:0][PAGE_WORDS-1:0][15:0] nvm;
        // Stored copy of the header words
        logic [HDR_WORDS-1:0][15:0] hdr;
        // Slot after the newest stored page
        logic [2:0] nptr;
        // Log captured and locked
        logic present;
        // Last seen store toggle
        logic stq;
        // Last seen request toggle
        logic reqq;
        // Answer toggle towards the link
        logic ack;
        // Answer byte, stable while the toggle crosses
        logic [7:0] ack_data;
    } flr_main_s;

    // Registered state and its next value
    flr_main_s r_q;
    flr_main_s r_d;

    // Toggles and index crossing between the domains
    logic [1:0] sync_out;
    logic req_raw;
    logic store_raw;
    logic [7:0] req_idx;

    // ==========================================================
    // Elaboration checks
    initial begin
        // Pass must reach the last temperature step and fit the step field
        if (MUX_LAST_STEP < STEP_TEXT0 + NUM_TEMPS - 1 || MUX_LAST_STEP > 31) begin
            $error("flr_formatter: last multiplexer step out of range");
        end
        // Header words are the peaks followed by the temperatures
        if (HDR_WORDS != NUM_PEAKS + NUM_TEMPS) begin
            $error("flr_formatter: header words do not match peaks and temperatures");
        end
        // Page pointers are three bits wide
        if (NUM_PAGES < 1 || NUM_PAGES > 8) begin
            $error("flr_formatter: page count out of range");
        end
        // Measured words of a page fit its byte slot and the step index
        if (2 * PAGE_WORDS > PAGE_BYTES || PAGE_WORDS > 8) begin
            $error("flr_formatter: page words do not fit a page");
        end
        // Pages fill the record up to its last byte
        if (OFS_EVT + NUM_PAGES * PAGE_BYTES != REC_LEN) begin
            $error("flr_formatter: pages do not fill the record");
        end
        // Top byte index is kept for the length byte
        if (REC_LEN > 255) begin
            $error("flr_formatter: record too long for the byte index");
        end
    end

    // ==========================================================
    // Link side and crossings
    flr_link u_link (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .cmd(link_cmd),
        .byte_req(link_byte_req),
        .rd(link_byte),
        .req_tgl(req_raw),
        .req_idx(req_idx),
        .store_tgl(store_raw),
        .ack_tgl(r_q.ack),
        .ack_data(r_q.ack_data)
    );

    // Request and store toggles into the device domain
    flr_sync #(.W(2)) u_req_sync (
        .clk(clk),
        .rst(rst),
        .d({store_raw, req_raw}),
        .q(sync_out)
    );

    // ==========================================================
    // Record byte lookup
    function automatic logic [7:0] rec_byte(input logic [7:0] idx, input flr_main_s s);
        logic [7:0] r;
        logic [2:0] k;
        logic [4:0] off;
        logic [3:0] ph;
        flr_word_t w;
        r = 8'h00;
        k = 3'd0;
        off = 5'd0;
        ph = 4'd0;
        w = WORD_RST;
        // Length byte ahead of the record
        if (idx == IDX_LEN) begin
            return s.present ? 8'(REC_LEN) : BYTE_RST; // R12
        end
        // Empty log, preface and out-of-range bytes read zero
        if (!s.present || idx < 8'(OFS_VPK0) || idx >= 8'(REC_LEN)) begin
            return BYTE_RST;
        end
        // Header words, one per byte pair
        if (idx < 8'(OFS_EVT)) begin
            r = 8'(idx - 8'(OFS_VPK0));
            w = s.hdr[r[3:1]]; // R2 R3 R4 R5 R6
            return r[0] ? w[7:0] : w[15:8]; // R11
        end
        // Event pages; status bytes beyond the words read zero
        r = 8'(idx - 8'(OFS_EVT));
        k = 3'(r / 8'(PAGE_BYTES));
        off = 5'(r % 8'(PAGE_BYTES));
        if (off >= 5'(2 * PAGE_WORDS)) begin
            return BYTE_RST;
        end
        // Newest page sits just behind the write pointer
        ph = 4'(4'(s.nptr) + 4'(NUM_PAGES - 1) - 4'(k));
        if (ph >= 4'(NUM_PAGES)) begin
            ph = 4'(ph - 4'(NUM_PAGES));
        end
        w = s.nvm[ph[2:0]][off[4:1]]; // R7
        return off[0] ? w[7:0] : w[15:8]; // R11
    endfunction : rec_byte

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic last;
        logic trig;
        logic [2:0] wnext;
        logic bigger;
        last = 1'b0;
        trig = 1'b0;
        wnext = 3'd0;
        bigger = 1'b0;
        // Every register holds unless a branch below moves it
        r_d = r_q;

        // End of a multiplexer pass
        last = meas.valid && meas.step == 5'(MUX_LAST_STEP);
        wnext = (r_q.wptr == 3'(NUM_PAGES - 1)) ? 3'd0 : 3'(r_q.wptr + 3'd1);

        // Store command edge and fault share one trigger
        r_d.stq = sync_out[1];
        trig = fault || (sync_out[1] != r_q.stq); // R13

        // Running maxima per measured quantity
        for (int i = 0; i < NUM_PEAKS; i++) begin
            // Output voltages compare as mantissas, the rest by value
            if (i < STEP_IOUT0) begin
                bigger = meas.data > r_q.pk[i];
            end else begin
                bigger = flr_l11_val(meas.data) > flr_l11_val(r_q.pk[i]);
            end
            // Clear wins over a sample in the same cycle
            if (peak_clear_command) begin
                r_d.fresh[i] = 1'b0; // R14
            end else if (meas.valid && meas.step == 5'(STEP_VOUT0 + i)) begin
                if (!r_q.fresh[i] || bigger) begin
                    r_d.pk[i] = meas.data; // R1 R14
                end
                r_d.fresh[i] = 1'b1;
            end
        end

        // Working page and temperatures of the current pass
        if (meas.valid && meas.step < 5'(PAGE_WORDS)) begin
            r_d.work[meas.step[2:0]] = meas.data; // R7
        end
        for (int t = 0; t < NUM_TEMPS; t++) begin
            if (meas.valid && meas.step == 5'(STEP_TEXT0 + t)) begin
                r_d.tmp[t] = meas.data; // R5 R6
            end
        end

        // Completed pass enters the cyclic buffer
        if (last) begin
            r_d.ring[r_q.wptr] = r_d.work; // R8
            r_d.wptr = wnext;
        end

        // Capture sequencer
        case (r_q.st)
            ST_IDLE: begin
                if (trig && !r_q.present) begin
                    r_d.st = ST_WAIT; // R9
                end
            end
            ST_WAIT: begin
                // Hold until the pass in progress ends
                r_d.st = ST_WAIT;
            end
            ST_STORE: begin
                // One page copied per cycle
                r_d.nvm[r_q.pg] = r_q.ring[r_q.pg]; // R10
                if (r_q.pg == 3'(NUM_PAGES - 1)) begin
                    r_d.present = 1'b1; // R10
                    r_d.st = ST_IDLE;
                end else begin
                    r_d.pg = 3'(r_q.pg + 3'd1);
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase

        // Freeze the header once the fault's pass has completed
        if (last && (r_q.st == ST_WAIT || (r_q.st == ST_IDLE && trig && !r_q.present))) begin
            for (int h = 0; h < NUM_PEAKS; h++) begin
                r_d.hdr[h] = r_d.pk[h]; // R2 R3 R4
            end
            for (int t = 0; t < NUM_TEMPS; t++) begin
                r_d.hdr[NUM_PEAKS + t] = r_d.tmp[t]; // R5 R6
            end
            r_d.nptr = wnext;
            r_d.pg = 3'd0;
            r_d.st = ST_STORE; // R9 R10
        end

        // Answer one byte fetch from the link
        r_d.reqq = sync_out[0];
        if (sync_out[0] != r_q.reqq) begin
            r_d.ack_data = rec_byte(req_idx, r_q); // R12
            r_d.ack = ~r_q.ack;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // Outputs
    // Log stays locked once stored
    assign log_present = r_q.present;
    // Busy from trigger until the last page is written
    assign store_busy = r_q.st[0]; // Set in wait and store states

endmodule : flr_formatter
`default_nettype wire

/* File: rtl/flr_link.sv */
// Purpose: Link-side command and byte fetch logic of the fault record.
// Assumes: Commands and byte requests are one-cycle pulses on link_clk.
// Notes: One byte in flight; requests while waiting are ignored.
`timescale 1ns/1ps
`default_nettype none
module flr_link
    import flr_pkg::*;
(
    input wire logic link_clk,
    input wire logic link_rst,
    input wire flr_cmd_s cmd,
    input wire logic byte_req,
    output flr_byte_s rd,
    output logic req_tgl,
    output logic [7:0] req_idx,
    output logic store_tgl,
    input wire logic ack_tgl,
    input wire logic [7:0] ack_data
);

    typedef struct packed {
        flr_lst_e st;
        logic armed;
        logic [7:0] idx;
        logic req;
        logic stt;
        logic ackq;
        flr_byte_s out;
    } flr_link_s;

    flr_link_s r_q;
    flr_link_s r_d;
    logic ack_s;

    // Answer toggle from the device domain
    flr_sync #(.W(1)) u_ack_sync (
        .clk(link_clk),
        .rst(link_rst),
        .d(ack_tgl),
        .q(ack_s)
    );

    // Command decode and byte fetch handshake
    always_comb begin
        r_d = r_q;
        r_d.out.valid = 1'b0;
        if (cmd.valid && cmd.code == CMD_STORE) begin
            r_d.stt = ~r_q.stt; // R13
        end
        case (r_q.st)
            LS_IDLE: begin
                if (cmd.valid && cmd.code == CMD_READ) begin
                    r_d.armed = 1'b1; // R12
                    r_d.idx = IDX_LEN;
                end else if (byte_req && r_q.armed) begin
                    r_d.req = ~r_q.req;
                    r_d.st = LS_WAIT;
                end
            end
            LS_WAIT: begin
                if (ack_s != r_q.ackq) begin
                    r_d.ackq = ack_s;
                    r_d.out.valid = 1'b1;
                    r_d.out.data = ack_data;
                    r_d.st = LS_IDLE;
                    r_d.idx = (r_q.idx == IDX_LEN) ? 8'h00 : 8'(r_q.idx + 8'h01);
                    if ((r_q.idx == IDX_LEN && ack_data == BYTE_RST)
                        || r_q.idx == 8'(REC_LEN - 1)) begin
                        r_d.armed = 1'b0; // R12
                    end
                end
            end
            default: begin
                r_d.st = LS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign rd = r_q.out;
    assign req_tgl = r_q.req;
    assign req_idx = r_q.idx;
    assign store_tgl = r_q.stt;

endmodule : flr_link
`default_nettype wire

/* File: rtl/flr_pkg.sv */
// Purpose: Shared constants and types of the fault log record formatter.
// Assumes: Record byte numbers count from byte 0 of the block data.
// Notes: Bytes 0 to 10 and event status bytes read as zero here.
package flr_pkg;

    // ==========================================================
    // Record layout
    localparam int REC_LEN = 147;
    localparam int OFS_VPK0 = 11;
    localparam int OFS_VPK1 = 13;
    localparam int OFS_IPK0 = 15;
    localparam int OFS_IPK1 = 17;
    localparam int OFS_VINPK = 19;
    localparam int OFS_TEXT0 = 21;
    localparam int OFS_TEXT1 = 23;
    localparam int OFS_TDIE = 25;
    localparam int OFS_EVT = 27;
    localparam int OFS_EVT_IOUT = 31;
    localparam int HDR_WORDS = (OFS_EVT - OFS_VPK0) / 2;
    localparam int PAGE_BYTES = 20;
    localparam int NUM_PAGES = 6;
    localparam int PAGE_WORDS = 6;
    localparam int NUM_PEAKS = 5;
    localparam int NUM_TEMPS = 3;

    // ==========================================================
    // Multiplexer steps
    localparam int STEP_VOUT0 = 0;
    localparam int STEP_IOUT0 = (OFS_EVT_IOUT - OFS_EVT) / 2;
    localparam int STEP_TEXT0 = 6;
    localparam int LAST_STEP = 25;

    // ==========================================================
    // Commands and reset values
    localparam logic [7:0] CMD_STORE = 8'hEA;
    localparam logic [7:0] CMD_READ = 8'hEE;
    localparam logic [7:0] IDX_LEN = 8'hFF;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // ==========================================================
    // Carriers
    typedef logic [15:0] flr_word_t;

    typedef struct packed {
        logic valid;
        logic [4:0] step;
        flr_word_t data;
    } flr_meas_s;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } flr_cmd_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } flr_byte_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_STORE = 2'b11
    } flr_st_e;

    typedef enum logic {
        LS_IDLE = 1'b0,
        LS_WAIT = 1'b1
    } flr_lst_e;

    // ==========================================================
    // Linear-11 word to a signed fixed value for comparison
    function automatic logic signed [42:0] flr_l11_val(input flr_word_t w);
        logic signed [42:0] m;
        logic [4:0] sh;
        m = 43'(signed'(w[10:0]));
        sh = w[15:11] ^ 5'h10; // Exponent plus sixteen
        return m <<< sh;
    endfunction : flr_l11_val

endpackage : flr_pkg

/* File: rtl/flr_sync.sv */
// Purpose: Two-stage synchroniser for level and toggle signals.
// Assumes: Each bit is independent; words cross by handshake elsewhere.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
`default_nettype none
module flr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } flr_sync_s;

    flr_sync_s r_q;
    flr_sync_s r_d;

    initial begin
        if (W < 1) $error("flr_sync: width must be positive");
    end

    // Shift through two flops
    always_comb begin
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;

endmodule : flr_sync
`default_nettype wire

/* File: sim/flr_formatter_assertions.sv */
// Purpose: Port checker of the fault record formatter.
// Assumes: Bound to every flr_formatter instance.
// Notes: Two clock domains, each with its own reset.
`timescale 1ns/1ps
`default_nettype none
module flr_formatter_assertions
    import flr_pkg::*;
#(
    parameter int MUX_LAST_STEP = LAST_STEP
) (
    input wire logic clk,
    input wire logic rst,
    input wire flr_meas_s meas,
    input wire logic fault,
    input wire logic link_clk,
    input wire logic link_rst,
    input wire flr_byte_s link_byte,
    input wire logic log_present,
    input wire logic store_busy
);
    // ==========================================================
    // Capture steps
    sequence s_armed;
        store_busy && !log_present;
    endsequence
    sequence s_pass_end;
        meas.valid && (meas.step == 5'(MUX_LAST_STEP));
    endsequence

    AST_BUSY_ON: assert property (@(posedge clk) disable iff (rst)
        fault && !store_busy && !log_present |=> store_busy)
        else $error("fault did not start capture");
    AST_PASS_END: assert property (@(posedge clk) disable iff (rst)
        s_armed ##0 s_pass_end |-> ##[6:8] log_present)
        else $error("log not stored after pass end");
    AST_BUSY_MIN: assert property (@(posedge clk) disable iff (rst)
        $rose(store_busy) |-> store_busy[*6])
        else $error("capture ended too early");
    AST_DONE: assert property (@(posedge clk) disable iff (rst)
        $fell(store_busy) |-> log_present)
        else $error("busy fell without stored log");
    AST_CAUSE: assert property (@(posedge clk) disable iff (rst)
        $rose(log_present) |-> $past(store_busy))
        else $error("log appeared without store");
    AST_LOCK: assert property (@(posedge clk) disable iff (rst)
        log_present |=> log_present && !store_busy)
        else $error("stored log lost or busy again");
    // ==========================================================
    // Link side
    AST_BYTE_PULSE: assert property (@(posedge link_clk) disable iff (link_rst)
        link_byte.valid |=> !link_byte.valid)
        else $error("byte valid longer than one cycle");
    AST_BYTE_HOLD: assert property (@(posedge link_clk) disable iff (link_rst)
        !link_byte.valid |-> $stable(link_byte.data))
        else $error("byte data changed without valid");
endmodule : flr_formatter_assertions

bind flr_formatter flr_formatter_assertions #(.MUX_LAST_STEP(MUX_LAST_STEP)) u_chk (
    .clk(clk), .rst(rst), .meas(meas), .fault(fault), .link_clk(link_clk),
    .link_rst(link_rst), .link_byte(link_byte), .log_present(log_present),
    .store_busy(store_busy));
`default_nettype wire

/* File: sim/flr_host.sv */
// Purpose: Host model reading and storing the fault record.
// Assumes: Called from the bench; drives on link clock edges.
// Notes: Missing answers are counted in timeouts.
`timescale 1ns/1ps
`default_nettype none
module flr_host
    import flr_pkg::*;
(
    input wire logic link_clk,
    output var flr_cmd_s cmd,
    output var logic byte_req,
    input wire flr_byte_s rd
);
    logic [7:0] rec [0:REC_LEN];
    int timeouts;

    // ==========================================================
    // Idle levels
    initial begin
        cmd = '0;
        byte_req = 1'b0;
        timeouts = 0;
    end

    // One-cycle command pulse
    task automatic send_cmd(input logic [7:0] code);
        @(posedge link_clk);
        cmd <= '{valid: 1'b1, code: code};
        @(posedge link_clk);
        cmd <= '0;
    endtask : send_cmd

    // Fetch one byte after an optional pause
    task automatic fetch(input int gap, output logic [7:0] b);
        int n;
        repeat (gap + 1) @(posedge link_clk);
        byte_req <= 1'b1;
        @(posedge link_clk);
        byte_req <= 1'b0;
        n = 0;
        do begin
            @(posedge link_clk);
            n++;
        end while (rd.valid !== 1'b1 && n < 20);
        if (n >= 20) timeouts++;
        b = rd.data;
    endtask : fetch

    // Block read: length byte, then the record
    task automatic read_log;
        send_cmd(CMD_READ);
        fetch(0, rec[0]);
        if (rec[0] != 8'h00) begin
            for (int i = 1; i <= REC_LEN; i++) fetch(i % 3, rec[i]);
        end
    endtask : read_log
endmodule : flr_host
`default_nettype wire

/* File: sim/tb_flr_formatter.sv */
// Purpose: Self-checking bench of the fault record formatter.
// Assumes: Host model on the link side.
// Notes: Link clock free running, unrelated phase.
`timescale 1ns/1ps
`default_nettype none
module tb_flr_formatter
    import flr_pkg::*;
;
    logic clk, rst, link_clk, link_rst, peak_clear_command, fault;
    logic link_byte_req, log_present, store_busy;
    flr_meas_s meas;
    flr_cmd_s link_cmd;
    flr_byte_s link_byte;
    int failures, tests_run, cycles;
    flr_word_t pv [0:2][0:8];
    flr_word_t hx [0:13];

    // ==========================================================
    // Clocks and instances
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end
    flr_formatter #(.MUX_LAST_STEP(LAST_STEP)) DUT (.clk(clk), .rst(rst), .meas(meas),
        .peak_clear_command(peak_clear_command), .fault(fault), .link_clk(link_clk),
        .link_rst(link_rst), .link_cmd(link_cmd), .link_byte_req(link_byte_req),
        .link_byte(link_byte), .log_present(log_present), .store_busy(store_busy));
    flr_host u_host (.link_clk(link_clk), .cmd(link_cmd), .byte_req(link_byte_req),
        .rd(link_byte));

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        failures += u_host.timeouts;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        link_rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge link_clk);
        link_rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    // One full mux pass of table k, fault pulse at step fs
    task automatic pass(input int k, input int fs);
        @(posedge clk);
        for (int s = 0; s <= LAST_STEP; s++) begin
            meas <= '{valid: 1'b1, step: 5'(s), data: (s < 9) ? pv[k][s] : 16'h0100 + 16'(s)};
            fault <= (s == fs);
            @(posedge clk);
        end
        meas <= '0;
        fault <= 1'b0;
    endtask : pass

    // ==========================================================
    // Scenarios
    task automatic test_empty;
        u_host.read_log();
        check(u_host.rec[0], 8'h00);
        check({7'h00, log_present}, 8'h00);
        $display("test_empty done");
    endtask : test_empty

    task automatic test_capture;
        pass(0, 99);
        @(posedge clk);
        peak_clear_command <= 1'b1;
        @(posedge clk);
        peak_clear_command <= 1'b0;
        pass(1, 99);
        pass(2, 10);
        check({6'h00, store_busy, log_present}, 8'h02);
        repeat (10) @(posedge clk);
        check({6'h00, store_busy, log_present}, 8'h01);
        u_host.read_log();
        check(u_host.rec[0], 8'(REC_LEN));
        check(u_host.rec[1], 8'h00);
        for (int w = 0; w < 14; w++) begin
            check(u_host.rec[12 + 2 * w], hx[w][15:8]);
            check(u_host.rec[13 + 2 * w], hx[w][7:0]);
        end
        pass(0, 3);
        repeat (10) @(posedge clk);
        check({6'h00, store_busy, log_present}, 8'h01);
        $display("test_capture done");
    endtask : test_capture

    task automatic test_store;
        u_host.send_cmd(CMD_STORE);
        repeat (8) @(posedge clk);
        check({7'h00, store_busy}, 8'h01);
        pass(2, 99);
        repeat (10) @(posedge clk);
        check({7'h00, log_present}, 8'h01);
        u_host.read_log();
        check(u_host.rec[0], 8'(REC_LEN));
        check(u_host.rec[28], 8'h09);
        $display("test_store done");
    endtask : test_store

    // ==========================================================
    // Watchdog
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        link_rst = 1'b1;
        meas = '0;
        fault = 1'b0;
        peak_clear_command = 1'b0;
        failures = 0;
        tests_run = 0;
        cycles = 0;
        pv = '{'{16'h3000, 16'h3000, 16'hD3F0, 16'hD3F0, 16'hD3F0, 16'h0001,
                 16'hE001, 16'hE002, 16'hE003},
               '{16'h0800, 16'h2100, 16'hD008, 16'hE004, 16'hD040, 16'h0002,
                 16'hE011, 16'hE012, 16'hE013},
               '{16'h0900, 16'h2000, 16'hD004, 16'hD020, 16'hD030, 16'hD001,
                 16'hE019, 16'hE01A, 16'hE01B}};
        hx = '{16'h0900, 16'h2100, 16'hD008, 16'hD020, 16'hD040, 16'hE019, 16'hE01A,
               16'hE01B, 16'h0900, 16'h2000, 16'hD004, 16'hD020, 16'hD030, 16'hD001};
        do_reset();
        test_empty();
        test_capture();
        do_reset();
        test_store();
        print_verdict();
    end
endmodule : tb_flr_formatter
`default_nettype wire
